// ===== verilog/tlbmf_pkg.sv
// constants for translation buffer maintenance and fetch fault log
// Notes on behaviour
// R1: pseudo-LRU victims fully assoc, true LRU set assoc
// R2: address bits 17:16 select target buffer
// R3: bit 15 on write stores bad parity
// R4: index from bits 13:3, fully assoc low five
// R5: set assoc index bits give half and way
// R6: set assoc writes clear lock, fully assoc keep
// R7: no hashing; global entries go fully assoc
// R8: set assoc evictions move into fully assoc
// R9: skip write on index mismatch unless invalid
// R10: reading invalid entry returns zero
// R11: table size four bits at bit zero
// R12: extension bits 11:4 zero, 3:0 size
// R13: log error buffer and index with priority
// R14: marked bit follows uncorrectable, mark id stored
// R15: bits 31,30,29 uncorrectable, bus error, timeout
// R16: bits 27:26 multi-hit and parity lookup errors
// R17: bit 25 noncacheable faulting fetch
// R18: address space id 80 or 04 by level
// R19: fault type 0 on miss, 01 exception
// R20: context type primary, nucleus, illegal 11
// R21: fault valid on exception, overwritten if pending
// R22: status fields follow the update policy
// R23: maintenance write tags entry from tag access
package tlbmf_pkg;
    localparam logic [7:0]  OFF_FS_LO   = 8'h00;
    localparam logic [7:0]  OFF_FS_HI   = 8'h04;
    localparam logic [7:0]  OFF_TX_LO   = 8'h08;
    localparam logic [7:0]  OFF_TX_HI   = 8'h0c;
    localparam logic [7:0]  OFF_TAG     = 8'h10;
    localparam logic [7:0]  OFF_DIN     = 8'h14;
    localparam logic [7:0]  OFF_MST     = 8'h18;
    localparam int          WIN_BIT     = 18;
    localparam int          SEL_LSB     = 16;
    localparam int          INJ_BIT     = 15;
    localparam int          IDX_LSB     = 3;
    localparam int          TSEL_BIT    = 2;
    localparam logic [1:0]  SEL_FA      = 2'h0;
    localparam logic [1:0]  SEL_SA      = 2'h2;
    localparam int          ENT_VALID   = 31;
    localparam int          ENT_LARGE   = 30;
    localparam int          ENT_LOCK    = 6;
    localparam int          ENT_GLOBAL  = 0;
    localparam int          TAG_SM_LSB  = 13;
    localparam int          TAG_LG_LSB  = 22;
    localparam logic [63:0] FS_MASK     = 64'hcffe7fff_eeffbfbb;
    localparam logic [63:0] FS_RESET    = 64'h0;
    localparam logic [31:0] TAG_RESET   = 32'h0;
    localparam logic [3:0]  TSIZE_RESET = 4'h0;
    localparam logic [4:0]  TBL_MIN_LOG2 = 5'h09;
    localparam int          FS_SEL      = 62;
    localparam int          FS_IDX      = 49;
    localparam int          FS_MARK     = 46;
    localparam int          FS_MID      = 32;
    localparam int          FS_UC       = 31;
    localparam int          FS_BUS      = 30;
    localparam int          FS_BTMO     = 29;
    localparam int          FS_MHIT     = 27;
    localparam int          FS_PAR      = 26;
    localparam int          FS_NC       = 25;
    localparam int          FS_SPC      = 16;
    localparam int          FS_MISS     = 15;
    localparam int          FS_FTY      = 7;
    localparam int          FS_CTX      = 4;
    localparam int          FS_PRV      = 3;
    localparam int          FS_OVW      = 1;
    localparam int          FS_VLD      = 0;
    localparam logic [7:0]  SPC_PRIMARY = 8'h80;
    localparam logic [7:0]  SPC_NUCLEUS = 8'h04;
    localparam logic [6:0]  FTY_PRIV    = 7'h01;
    localparam logic [6:0]  FTY_NONE    = 7'h00;
    localparam logic [1:0]  CTX_PRIMARY = 2'h0;
    localparam logic [1:0]  CTX_NUCLEUS = 2'h2;
    localparam logic [1:0]  CTX_ILLEGAL = 2'h3;
endpackage : tlbmf_pkg

// ===== verilog/tlbmf_maint.sv
// translation buffer maintenance port and instruction fault status log
`timescale 1ns/1ps
module tlbmf_maint #(
    parameter int FA_N = 32,
    parameter int SA_N = 2048
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [19:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    input  wire logic        fetch_miss_i,
    input  wire logic        fetch_check_i,
    input  wire logic        privileged_page_bit_i,
    input  wire logic        priv_state_bit_i,
    input  wire logic [2:0]  trap_level_i,
    input  wire logic        ctx_illegal_i,
    input  wire logic        fetch_err_i,
    input  wire logic        uncorrectable_flag_i,
    input  wire logic        bus_error_flag_i,
    input  wire logic        bus_timeout_flag_i,
    input  wire logic        noncacheable_i,
    input  wire logic [13:0] error_mark_id_i,
    input  wire logic        lk_fa_par_i,
    input  wire logic        lk_sa_par_i,
    input  wire logic        lk_sa_mhit_i,
    input  wire logic        lk_fa_mhit_i,
    input  wire logic [4:0]  lk_fa_idx_i,
    input  wire logic [10:0] lk_sa_idx_i,
    output logic [3:0]       table_size_field_o,
    output logic [4:0]       table_log2_entries_o
);
    localparam int FA_W = $clog2(FA_N);
    localparam int SA_W = $clog2(SA_N);
    localparam int SET_W = SA_W - 2;

    logic [31:0]      fa_ent [FA_N];
    logic [31:0]      fa_tag [FA_N];
    logic             fa_par [FA_N];
    logic [FA_N-1:0]  fa_used;
    logic [31:0]      sa_ent [SA_N];
    logic [31:0]      sa_tag [SA_N];
    logic             sa_par [SA_N];
    logic [SA_N/2-1:0] sa_lru;
    logic [63:0]      fsr;
    logic [31:0]      tag_acc;
    logic [3:0]       tsize;
    logic             rd_par_err;
    logic             wr_skipped;
    logic [63:0]      next_fsr;

    function automatic logic [31:0] strb_mix(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        return r;
    endfunction : strb_mix

    // first entry not recently used
    function automatic logic [FA_W-1:0] plru_pick(input logic [FA_N-1:0] u);
        logic [FA_W-1:0] v;
        v = '0;
        for (int k = FA_N - 1; k >= 0; k--) begin
            if (!u[k]) begin
                v = FA_W'(k);
            end
        end
        return v;
    endfunction : plru_pick

    function automatic logic [FA_N-1:0] plru_touch(input logic [FA_N-1:0] u,
                                                   input logic [FA_W-1:0] i);
        logic [FA_N-1:0] m;
        m = '0;
        m[i] = 1'b1;
        return (&(u | m)) ? m : (u | m);
    endfunction : plru_touch

    function automatic logic [SET_W-1:0] tag_set(input logic [31:0] t, input logic lg);
        return lg ? t[tlbmf_pkg::TAG_LG_LSB +: SET_W] : t[tlbmf_pkg::TAG_SM_LSB +: SET_W];
    endfunction : tag_set

    // bus decode
    wire             setup_ph = psel_i & ~penable_i;
    wire             access_ph = psel_i & penable_i;
    wire             bus_wr = access_ph & pwrite_i;
    wire             in_win = paddr_i[tlbmf_pkg::WIN_BIT];
    wire [1:0]       bsel = paddr_i[tlbmf_pkg::SEL_LSB +: 2]; // [R2]
    wire             inject = paddr_i[tlbmf_pkg::INJ_BIT];
    wire [SA_W-1:0]  idx = paddr_i[tlbmf_pkg::IDX_LSB +: SA_W]; // [R4]
    wire [FA_W-1:0]  fa_i = idx[FA_W-1:0]; // [R4]
    wire             tsel = paddr_i[tlbmf_pkg::TSEL_BIT];
    wire             sel_fa = bsel == tlbmf_pkg::SEL_FA;
    wire             sel_sa = bsel == tlbmf_pkg::SEL_SA;
    wire             csr_sp = ~in_win & (paddr_i[19:8] == 12'h000);
    wire [7:0]       off = paddr_i[7:0];
    wire             hit_fl = csr_sp & (off == tlbmf_pkg::OFF_FS_LO);
    wire             hit_fh = csr_sp & (off == tlbmf_pkg::OFF_FS_HI);
    wire             hit_xl = csr_sp & (off == tlbmf_pkg::OFF_TX_LO);
    wire             hit_xh = csr_sp & (off == tlbmf_pkg::OFF_TX_HI);
    wire             hit_tg = csr_sp & (off == tlbmf_pkg::OFF_TAG);
    wire             hit_di = csr_sp & (off == tlbmf_pkg::OFF_DIN);
    wire             hit_ms = csr_sp & (off == tlbmf_pkg::OFF_MST);
    wire             csr_ok = hit_fl | hit_fh | hit_xl | hit_xh | hit_tg | hit_di | hit_ms;
    wire             addr_ok = in_win ? (sel_fa | sel_sa) : csr_ok; // [R2]

    // maintenance store through the window
    wire [31:0]      wd = pwdata_i;
    wire             wd_valid = wd[tlbmf_pkg::ENT_VALID];
    wire [31:0]      wd_unlk = wd & ~(32'h1 << tlbmf_pkg::ENT_LOCK); // [R6]
    wire             idx_match = tag_set(tag_acc, idx[SA_W-1]) == idx[SET_W-1:0];
    wire             idx_ok = sel_fa | ~wd_valid | idx_match; // [R9]
    wire             mw = bus_wr & in_win & addr_ok & ~tsel;
    wire             mw_fa = mw & sel_fa;
    wire             mw_sa = mw & sel_sa & idx_ok; // [R9]
    wire             mw_skip = mw & sel_sa & ~idx_ok;

    // data-in store: set from tag, half from page size, way by lru
    wire             dw = bus_wr & hit_di;
    wire             din_glob = wd[tlbmf_pkg::ENT_GLOBAL];
    wire             din_half = wd[tlbmf_pkg::ENT_LARGE];
    wire [SET_W-1:0] din_set = tag_set(tag_acc, din_half); // [R7]
    wire             din_way = sa_lru[{din_half, din_set}]; // [R1]
    wire [SA_W-1:0]  din_slot = {din_half, din_way, din_set}; // [R5]
    wire [31:0]      vic_ent = sa_ent[din_slot];
    wire             evict = dw & ~din_glob & vic_ent[tlbmf_pkg::ENT_VALID]; // [R8]
    wire [FA_W-1:0]  fa_vic = plru_pick(fa_used); // [R1]

    wire             fa_we = mw_fa | (dw & din_glob) | evict; // [R7] [R8]
    wire [FA_W-1:0]  fa_wi = mw_fa ? fa_i : fa_vic;
    wire [31:0]      fa_wd = evict ? vic_ent : wd; // [R6]
    wire [31:0]      fa_wt = evict ? sa_tag[din_slot] : tag_acc; // [R23]
    wire             fa_wp = evict ? sa_par[din_slot] : ((^wd) ^ (mw_fa & inject)); // [R3]
    wire             sa_we = mw_sa | (dw & ~din_glob);
    wire [SA_W-1:0]  sa_wi = mw_sa ? idx : din_slot; // [R5]
    wire             sa_wp = (^wd_unlk) ^ (mw_sa & inject); // [R3]
    wire [SA_W-2:0]  sa_li = {sa_wi[SA_W-1], sa_wi[SET_W-1:0]};

    // entry read with invalid entries reading zero
    wire [31:0]      rd_fe = fa_ent[fa_i];
    wire [31:0]      rd_se = sa_ent[idx];
    wire [31:0]      rd_e = sel_fa ? rd_fe : rd_se;
    wire [31:0]      rd_t = sel_fa ? fa_tag[fa_i] : sa_tag[idx];
    wire             rd_p = sel_fa ? fa_par[fa_i] : sa_par[idx];
    wire [31:0]      rd_win = ~rd_e[tlbmf_pkg::ENT_VALID] ? 32'h0 :
                              (tsel ? rd_t : rd_e); // [R10]
    wire             rd_bad = access_ph & ~pwrite_i & in_win & addr_ok &
                              rd_e[tlbmf_pkg::ENT_VALID] & (rd_p != ^rd_e);
    wire [31:0]      rd_csr = hit_fl ? fsr[31:0] :
                              hit_fh ? fsr[63:32] :
                              hit_xl ? {28'h0, tsize} : // [R12]
                              hit_tg ? tag_acc :
                              hit_ms ? {30'h0, wr_skipped, rd_par_err} : 32'h0;
    wire [31:0]      rd_val = !addr_ok ? 32'h0 : (in_win ? rd_win : rd_csr);

    assign pready_o = 1'b1;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0;
            pslverr_o <= 1'b0;
        end else if (setup_ph) begin
            prdata_o <= rd_val;
            pslverr_o <= ~addr_ok;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k < FA_N; k++) begin
                fa_ent[k] <= 32'h0;
                fa_tag[k] <= 32'h0;
                fa_par[k] <= 1'b0;
            end
            for (int k = 0; k < SA_N; k++) begin
                sa_ent[k] <= 32'h0;
                sa_tag[k] <= 32'h0;
                sa_par[k] <= 1'b0;
            end
            fa_used <= '0;
            sa_lru <= '0;
        end else begin
            if (fa_we) begin
                fa_ent[fa_wi] <= fa_wd;
                fa_tag[fa_wi] <= fa_wt;
                fa_par[fa_wi] <= fa_wp;
                fa_used <= plru_touch(fa_used, fa_wi); // [R1]
            end
            if (sa_we) begin
                sa_ent[sa_wi] <= wd_unlk; // [R6]
                sa_tag[sa_wi] <= tag_acc; // [R23]
                sa_par[sa_wi] <= sa_wp;
                sa_lru[sa_li] <= ~sa_wi[SET_W]; // [R1]
            end
        end
    end

    // table extension and maintenance status
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tag_acc <= tlbmf_pkg::TAG_RESET;
            tsize <= tlbmf_pkg::TSIZE_RESET;
            table_log2_entries_o <= tlbmf_pkg::TBL_MIN_LOG2;
            rd_par_err <= 1'b0;
            wr_skipped <= 1'b0;
        end else begin
            if (bus_wr & hit_tg) begin
                tag_acc <= strb_mix(tag_acc, wd, pstrb_i);
            end
            if (bus_wr & hit_xl & pstrb_i[0]) begin
                tsize <= wd[3:0]; // [R12]
                table_log2_entries_o <= tlbmf_pkg::TBL_MIN_LOG2 + {1'b0, wd[3:0]}; // [R11]
            end
            // set wins over a write-one clear
            rd_par_err <= rd_bad | (rd_par_err & ~(bus_wr & hit_ms & pstrb_i[0] & wd[0]));
            wr_skipped <= mw_skip | (wr_skipped & ~(bus_wr & hit_ms & pstrb_i[0] & wd[1]));
        end
    end

    assign table_size_field_o = tsize;

    // fault event decode
    wire             exc = fetch_check_i & privileged_page_bit_i & ~priv_state_bit_i; // [R19]
    wire             lk_any = lk_fa_par_i | lk_sa_par_i | lk_sa_mhit_i | lk_fa_mhit_i;
    wire             err = fetch_err_i | lk_any;
    wire             lv_nz = trap_level_i != 3'h0;
    wire [7:0]       ev_spc = lv_nz ? tlbmf_pkg::SPC_NUCLEUS : tlbmf_pkg::SPC_PRIMARY; // [R18]
    wire [1:0]       ev_ctx = ctx_illegal_i ? tlbmf_pkg::CTX_ILLEGAL :
                              (lv_nz ? tlbmf_pkg::CTX_NUCLEUS : tlbmf_pkg::CTX_PRIMARY); // [R20]
    wire             lk_use_fa = lk_fa_par_i | (~lk_sa_par_i & ~lk_sa_mhit_i); // [R13]
    wire [1:0]       lk_sel = lk_use_fa ? tlbmf_pkg::SEL_FA : tlbmf_pkg::SEL_SA; // [R13]
    wire [10:0]      lk_idx = lk_use_fa ? {6'h0, lk_fa_idx_i} : lk_sa_idx_i; // [R13]
    wire [31:0]      sw_lo = (bus_wr & hit_fl) ? strb_mix(fsr[31:0], wd, pstrb_i) : fsr[31:0];
    wire [31:0]      sw_hi = (bus_wr & hit_fh) ? strb_mix(fsr[63:32], wd, pstrb_i) : fsr[63:32];
    wire [63:0]      sw_fsr = {sw_hi, sw_lo} & tlbmf_pkg::FS_MASK;

    // update policy; a hardware event overrides a same-cycle software write
    always_comb begin
        next_fsr = sw_fsr;
        if (err) begin
            next_fsr[tlbmf_pkg::FS_VLD] = 1'b1; // [R21] [R22]
            next_fsr[tlbmf_pkg::FS_OVW] = sw_fsr[tlbmf_pkg::FS_VLD]; // [R21]
            next_fsr[tlbmf_pkg::FS_PRV] = priv_state_bit_i;
            next_fsr[tlbmf_pkg::FS_CTX +: 2] = ev_ctx;
            next_fsr[tlbmf_pkg::FS_SPC +: 8] = ev_spc;
            next_fsr[tlbmf_pkg::FS_UC] = fetch_err_i & uncorrectable_flag_i; // [R15]
            next_fsr[tlbmf_pkg::FS_BUS] = fetch_err_i & bus_error_flag_i; // [R15]
            next_fsr[tlbmf_pkg::FS_BTMO] = fetch_err_i & bus_timeout_flag_i; // [R15]
            next_fsr[tlbmf_pkg::FS_MARK] = fetch_err_i & uncorrectable_flag_i; // [R14]
            next_fsr[tlbmf_pkg::FS_MID +: 14] = error_mark_id_i; // [R14]
            next_fsr[tlbmf_pkg::FS_NC] = fetch_err_i & noncacheable_i; // [R17]
            next_fsr[tlbmf_pkg::FS_MHIT] = lk_sa_mhit_i | lk_fa_mhit_i; // [R16]
            next_fsr[tlbmf_pkg::FS_PAR] = lk_fa_par_i | lk_sa_par_i; // [R16]
            if (lk_any) begin
                next_fsr[tlbmf_pkg::FS_SEL +: 2] = lk_sel; // [R13]
                next_fsr[tlbmf_pkg::FS_IDX +: 11] = lk_idx; // [R13]
            end
        end else if (exc) begin
            next_fsr[tlbmf_pkg::FS_VLD] = 1'b1; // [R21] [R22]
            next_fsr[tlbmf_pkg::FS_OVW] = sw_fsr[tlbmf_pkg::FS_VLD]; // [R21]
            next_fsr[tlbmf_pkg::FS_PRV] = priv_state_bit_i;
            next_fsr[tlbmf_pkg::FS_CTX +: 2] = ev_ctx;
            next_fsr[tlbmf_pkg::FS_SPC +: 8] = ev_spc;
            next_fsr[tlbmf_pkg::FS_FTY +: 7] = tlbmf_pkg::FTY_PRIV; // [R19]
        end else if (fetch_miss_i) begin
            next_fsr[tlbmf_pkg::FS_MISS] = 1'b1; // [R22]
            if (!sw_fsr[tlbmf_pkg::FS_VLD]) begin
                next_fsr[tlbmf_pkg::FS_OVW] = 1'b0; // [R22]
                next_fsr[tlbmf_pkg::FS_PRV] = priv_state_bit_i;
                next_fsr[tlbmf_pkg::FS_CTX +: 2] = ev_ctx;
                next_fsr[tlbmf_pkg::FS_FTY +: 7] = tlbmf_pkg::FTY_NONE; // [R19]
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fsr <= tlbmf_pkg::FS_RESET;
        end else begin
            fsr <= next_fsr;
        end
    end

    // checks
    sequence s_exc_alone;
        exc && !err;
    endsequence
    sequence s_fresh_miss;
        fetch_miss_i && !exc && !err && !sw_fsr[tlbmf_pkg::FS_VLD];
    endsequence

    chk_exc_sets_vld: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R21]
        s_exc_alone |=> fsr[tlbmf_pkg::FS_VLD] && fsr[tlbmf_pkg::FS_FTY +: 7] == 7'h01)
        else $error("exception did not set fault valid and type");
    chk_miss_no_vld: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R22]
        s_fresh_miss |=> fsr[tlbmf_pkg::FS_MISS] && !fsr[tlbmf_pkg::FS_VLD] &&
        !fsr[tlbmf_pkg::FS_OVW])
        else $error("fresh miss status wrong");
    chk_ovw_pending: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R21]
        (exc || err) && sw_fsr[tlbmf_pkg::FS_VLD] |=> fsr[tlbmf_pkg::FS_OVW])
        else $error("overwritten not set");
    chk_spc_level: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R18]
        s_exc_alone ##0 (trap_level_i != 3'h0) |=> fsr[23:16] == 8'h04)
        else $error("nucleus asi not recorded");
    chk_mark_follows: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R14]
        err && fetch_err_i && uncorrectable_flag_i |=> fsr[46] && fsr[31])
        else $error("marked bit missing with uncorrectable");
    chk_err_prio: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R13]
        lk_fa_par_i |=> fsr[63:62] == 2'h0 && fsr[59:49] == {6'h0, $past(lk_fa_idx_i)})
        else $error("fully assoc parity not logged first");
    chk_ext_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R12]
        setup_ph && hit_xl |=> prdata_o[31:4] == 28'h0 && prdata_o[3:0] == tsize)
        else $error("extension reserved bits not zero");
    chk_inval_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R10]
        setup_ph && in_win && addr_ok && !rd_e[31] |=> prdata_o == 32'h0)
        else $error("invalid entry read not zero");
    chk_lock_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R6]
        sa_we |=> !sa_ent[$past(sa_wi)][tlbmf_pkg::ENT_LOCK])
        else $error("lock kept in set assoc buffer");
    chk_skip_write: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R9]
        mw_skip |=> wr_skipped && sa_ent[$past(idx)] == $past(sa_ent[idx]))
        else $error("mismatched write not skipped");
    chk_global_fa: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R7]
        dw && din_glob |=> fa_ent[$past(fa_vic)] == $past(wd) && $stable(sa_lru))
        else $error("global entry not placed in fully assoc");
    sequence s_evict;
        evict;
    endsequence
    chk_evict_move: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R8]
        s_evict |=> fa_ent[$past(fa_vic)] == $past(vic_ent) &&
        fa_tag[$past(fa_vic)] == $past(sa_tag[din_slot]))
        else $error("dropped entry not moved to fully assoc");
    chk_lru_flip: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R1]
        sa_we |=> sa_lru[$past(sa_li)] != $past(sa_wi[SET_W]))
        else $error("set assoc lru still points at used way");
    chk_bad_select: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R2]
        setup_ph && in_win && !sel_fa && !sel_sa |=> pslverr_o && prdata_o == 32'h0)
        else $error("reserved buffer select accepted");
endmodule : tlbmf_maint

// ===== verif/tlbmf_core_model.sv
// core fetch side model: raises fault and lookup events for one cycle
`timescale 1ns/1ps
module tlbmf_core_model (
    input  wire logic   clock_i,
    output logic        fetch_miss_i, fetch_check_i, fetch_err_i, lk_fa_par_i,
    output logic        lk_sa_par_i, lk_sa_mhit_i, lk_fa_mhit_i, ctx_illegal_i,
    output logic        privileged_page_bit_i, priv_state_bit_i, noncacheable_i,
    output logic        uncorrectable_flag_i, bus_error_flag_i, bus_timeout_flag_i,
    output logic [2:0]  trap_level_i,
    output logic [13:0] error_mark_id_i,
    output logic [4:0]  lk_fa_idx_i,
    output logic [10:0] lk_sa_idx_i
);
    task automatic put(input logic [6:0] ev, q, input logic [2:0] lv,
                       input logic [13:0] error_mark_id, input logic [10:0] idx);
        {fetch_miss_i, fetch_check_i, fetch_err_i, lk_fa_par_i} <= ev[6:3];
        {lk_sa_par_i, lk_sa_mhit_i, lk_fa_mhit_i} <= ev[2:0];
        {privileged_page_bit_i, priv_state_bit_i, ctx_illegal_i} <= q[6:4];
        {uncorrectable_flag_i, bus_error_flag_i, bus_timeout_flag_i, noncacheable_i} <= q[3:0];
        {trap_level_i, error_mark_id_i, lk_sa_idx_i, lk_fa_idx_i} <= {lv, error_mark_id, idx, idx[4:0]};
    endtask : put
    initial put(7'h0, 7'h0, 3'h0, 14'h0, 11'h0);
    // one pulse; qualifiers are scrambled once the pulse is gone
    task automatic fire(input logic [6:0] ev, q, input logic [2:0] lv,
                        input logic [13:0] error_mark_id, input logic [10:0] idx);
        @(posedge clock_i);
        put(ev, q, lv, error_mark_id, idx);
        @(posedge clock_i);
        put(7'h0, ~q, ~lv, ~error_mark_id, ~idx);
    endtask : fire
endmodule : tlbmf_core_model

// ===== verif/tb.sv
// self-checking bench for the maintenance port and fetch fault log
`timescale 1ns/1ps
module tb;
    localparam logic [1:0]  FA   = tlbmf_pkg::SEL_FA;
    localparam logic [1:0]  SA   = tlbmf_pkg::SEL_SA;
    localparam logic [31:0] ALL  = 32'hffffffff;
    localparam logic [31:0] LO_M = tlbmf_pkg::FS_MASK[31:0];
    localparam logic [31:0] HI_M = tlbmf_pkg::FS_MASK[63:32];
    localparam logic        OK   = 1'b0;
    localparam logic        BAD  = 1'b1;
    logic        clock_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic        fetch_miss_i, fetch_check_i, fetch_err_i, lk_fa_par_i, lk_sa_par_i;
    logic        lk_sa_mhit_i, lk_fa_mhit_i, ctx_illegal_i, privileged_page_bit_i;
    logic        priv_state_bit_i, noncacheable_i, uncorrectable_flag_i;
    logic        bus_error_flag_i, bus_timeout_flag_i;
    logic [2:0]  trap_level_i;
    logic [3:0]  pstrb_i, table_size_field_o;
    logic [4:0]  table_log2_entries_o, lk_fa_idx_i;
    logic [10:0] lk_sa_idx_i;
    logic [13:0] error_mark_id_i;
    logic [19:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    tlbmf_maint #(.FA_N(32), .SA_N(2048)) dut (.*);
    tlbmf_core_model core (.*);
    always #50 clock_i = ~clock_i;
    task automatic check(input string what, input logic [31:0] got, exp, m);
        cmp_count++;
        if ((got & m) !== (exp & m)) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp & m, got & m);
        end
    endtask : check
    // one transfer; on a read d is the expected data
    task automatic xf(input logic wr, input logic [19:0] a, input logic [31:0] d, m,
                      input logic e);
        @(posedge clock_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, wr, a, d};
        @(posedge clock_i);
        penable_i <= 1'b1;
        @(posedge clock_i);
        while (pready_o !== 1'b1) @(posedge clock_i);
        check("slave error", {31'h0, pslverr_o}, {31'h0, e}, ALL);
        if (!wr)
            check("read data", prdata_o, d, m);
        {psel_i, penable_i} <= 2'h0;
    endtask : xf
    function automatic logic [19:0] win(input logic [1:0] b, input logic inj,
                                        input logic [10:0] idx, input logic tg);
        return {2'b01, b, inj, 1'b0, idx, tg, 2'b00};
    endfunction : win
    task automatic t_regs();
        xf(1'b0, 20'h00000, 32'h0, ALL, OK);
        xf(1'b0, 20'h0001c, 32'h0, ALL, BAD);
        xf(1'b1, 20'h00008, 32'hffffffff, ALL, OK);
        xf(1'b0, 20'h00008, 32'h0000000f, ALL, OK);
        @(negedge clock_i);
        check("table size", {28'h0, table_size_field_o}, 32'hf, ALL);
        check("table log2", {27'h0, table_log2_entries_o}, 32'h18, ALL);
    endtask : t_regs
    task automatic t_exc();
        core.fire(7'h20, 7'h40, 3'h0, 14'h0, 11'h0);
        xf(1'b0, 20'h0, 32'h00800081, LO_M, OK);
        core.fire(7'h20, 7'h40, 3'h1, 14'h0, 11'h0);
        xf(1'b0, 20'h0, 32'h000400a3, LO_M, OK);
        core.fire(7'h40, 7'h00, 3'h0, 14'h0, 11'h0);
        xf(1'b0, 20'h0, 32'h000480a3, LO_M, OK);
        core.fire(7'h20, 7'h50, 3'h0, 14'h0, 11'h0);
        xf(1'b0, 20'h0, 32'h008080b3, LO_M, OK);
        xf(1'b1, 20'h0, 32'h0, ALL, OK);
        core.fire(7'h40, 7'h00, 3'h0, 14'h0, 11'h0);
        core.fire(7'h20, 7'h60, 3'h0, 14'h0, 11'h0);
        xf(1'b0, 20'h0, 32'h00008000, LO_M, OK);
    endtask : t_exc
    task automatic t_err();
        xf(1'b1, 20'h0, 32'h0, ALL, OK);
        xf(1'b1, 20'h4, 32'h0, ALL, OK);
        core.fire(7'h1c, 7'h09, 3'h0, 14'h1234, 11'h4f3);
        xf(1'b0, 20'h0, 32'h86800001, LO_M, OK);
        xf(1'b0, 20'h4, 32'h00265234, HI_M, OK);
        core.fire(7'h03, 7'h00, 3'h0, 14'h0, 11'h7ff);
        xf(1'b0, 20'h4, 32'h8ffe0000, 32'hcffe0000, OK);
        xf(1'b0, 20'h0, 32'h00000003, 32'h00000003, OK);
        core.fire(7'h10, 7'h06, 3'h0, 14'h0, 11'h0);
        xf(1'b0, 20'h0, 32'h60000000, 32'he0000000, OK);
    endtask : t_err
    task automatic t_maint();
        xf(1'b1, 20'h10, 32'h00020005, ALL, OK);
        xf(1'b1, win(SA, 1'b0, 11'h010, 1'b0), 32'h80000040, ALL, OK);
        xf(1'b1, win(SA, 1'b0, 11'h210, 1'b0), 32'h80000100, ALL, OK);
        xf(1'b0, win(SA, 1'b0, 11'h010, 1'b0), 32'h80000000, ALL, OK);
        xf(1'b0, win(SA, 1'b0, 11'h010, 1'b1), 32'h00020005, ALL, OK);
        xf(1'b0, win(SA, 1'b0, 11'h210, 1'b0), 32'h80000100, ALL, OK);
        xf(1'b1, win(SA, 1'b0, 11'h210, 1'b0), 32'h0, ALL, OK);
        xf(1'b0, win(SA, 1'b0, 11'h210, 1'b0), 32'h0, ALL, OK);
        xf(1'b1, win(SA, 1'b0, 11'h011, 1'b0), 32'h80000000, ALL, OK);
        xf(1'b0, win(SA, 1'b0, 11'h011, 1'b0), 32'h0, ALL, OK);
        xf(1'b0, 20'h18, 32'h2, 32'h2, OK);
        xf(1'b1, 20'h18, 32'h3, ALL, OK);
        xf(1'b1, win(FA, 1'b0, 11'h7e3, 1'b0), 32'h80000040, ALL, OK);
        xf(1'b0, win(FA, 1'b0, 11'h003, 1'b0), 32'h80000040, ALL, OK);
        xf(1'b0, 20'h18, 32'h0, ALL, OK);
        xf(1'b1, win(FA, 1'b1, 11'h004, 1'b0), 32'h80000002, ALL, OK);
        xf(1'b0, win(FA, 1'b1, 11'h004, 1'b0), 32'h80000002, ALL, OK);
        xf(1'b0, 20'h18, 32'h1, 32'h1, OK);
        xf(1'b1, win(2'h1, 1'b0, 11'h0, 1'b0), 32'h80000000, ALL, BAD);
        xf(1'b0, win(2'h3, 1'b0, 11'h0, 1'b0), 32'h0, ALL, BAD);
    endtask : t_maint
    task automatic t_din();
        xf(1'b1, 20'h14, 32'h80000100, ALL, OK);
        xf(1'b0, win(SA, 1'b0, 11'h010, 1'b0), 32'h80000100, ALL, OK);
        xf(1'b0, win(FA, 1'b0, 11'h0, 1'b0), 32'h80000000, ALL, OK);
        xf(1'b1, 20'h14, 32'h80000001, ALL, OK);
        xf(1'b0, win(FA, 1'b0, 11'h1, 1'b0), 32'h80000001, ALL, OK);
    endtask : t_din
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        clock_i = 1'b0;
        rst_n_i = 1'b0;
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = 55'h0;
        pstrb_i = 4'hf;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_exc();
        t_err();
        t_maint();
        t_din();
        give_verdict();
    end
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
endmodule : tb
